// >>> design/param_source_map.vh
// constants for the parameter source control block
// included by the control block and the bench; definitions only
`ifndef PARAM_SOURCE_MAP_VH
`define PARAM_SOURCE_MAP_VH
// wishbone register byte offsets
`define REG_CTRL0      8'h00
`define REG_MODE       8'h04
`define REG_PROF_SEL   8'h08
`define REG_PROF_FREQ  8'h0C
`define REG_PROF_PHASE 8'h10
`define REG_PROF_AMP   8'h14
`define REG_RAMP_UPPER 8'h18
`define REG_RAMP_LOWER 8'h1C
`define REG_RAMP_RSTEP 8'h20
`define REG_RAMP_FSTEP 8'h24
`define REG_RAMP_RRATE 8'h28
`define REG_RAMP_FRATE 8'h2C
`define REG_MOD_FREQ   8'h30
`define REG_STATUS     8'h34
`define REG_OUT_FREQ   8'h38
`define REG_OUT_PHASE  8'h3C
`define REG_OUT_AMP    8'h40
`define REG_KEY_AMP    8'h44
// first control register fields
`define CTRL0_KEY_EN   8
`define CTRL0_PD_LO    0
// mode register fields
`define MODE_PARALLEL  22
`define MODE_PROFILE   23
`define MODE_RAMP      19
`define MODE_MODULUS   17
`define MODE_TGT_LO    20
// ramp target encoding
`define TGT_FREQ       2'h0
`define TGT_PHASE      2'h1
`define TGT_AMP        2'h2
// reset values
`define CTRL0_RESET    32'h00000000
`define MODE_RESET     32'h00000000
// data clock divide ratio, sixteenth of sample rate
`define DCLK_DIV       16
`endif

// >>> design/ramp_generator.v
// 32-bit linear ramp between programmed limits
// steps on a one-cycle tick; pins arrive already synchronised
`timescale 1ns/100ps
`default_nettype none
module ramp_generator #(
  parameter WIDTH = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire enable_i,
  input wire dir_up_i,
  input wire pause_i,
  input wire [WIDTH-1:0] upper_i,
  input wire [WIDTH-1:0] lower_i,
  input wire [WIDTH-1:0] rise_step_i,
  input wire [WIDTH-1:0] fall_step_i,
  input wire [15:0] rise_rate_i,
  input wire [15:0] fall_rate_i,
  output reg [WIDTH-1:0] value_o,
  output reg at_limit_o
);
  reg [15:0] rate_cnt;
  reg [WIDTH:0] next_sum;
  wire [15:0] rate = dir_up_i ? rise_rate_i : fall_rate_i;
  wire tick = (rate_cnt >= rate);

  always @*
  begin
    if (dir_up_i)
      next_sum = {1'b0, value_o} + {1'b0, rise_step_i};
    else
      next_sum = {1'b0, value_o} - {1'b0, fall_step_i};
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      value_o <= {WIDTH{1'b0}};
      rate_cnt <= 16'h0000;
      at_limit_o <= 1'b0;
    end
    else if (!enable_i)
    begin
      value_o <= lower_i;
      rate_cnt <= 16'h0000;
      at_limit_o <= 1'b0;
    end
    else if (!pause_i)
    begin
      rate_cnt <= tick ? 16'h0000 : rate_cnt + 16'h0001;
      if (tick)
      begin
        // direction from the pin only, holds at limit
        if (dir_up_i && (next_sum[WIDTH] || next_sum[WIDTH-1:0] >= upper_i))
        begin
          value_o <= upper_i;
          at_limit_o <= 1'b1;
        end
        else if (!dir_up_i &&
                 (next_sum[WIDTH] || next_sum[WIDTH-1:0] <= lower_i))
        begin
          value_o <= lower_i;
          at_limit_o <= 1'b1;
        end
        else
        begin
          value_o <= next_sum[WIDTH-1:0];
          at_limit_o <= 1'b0;
        end
      end
    end
  end
endmodule // ramp_generator
`default_nettype wire

// >>> design/param_source_control.v
// parameter source selection with wishbone registers
// single clock; pins are asynchronous; control pins are synchronised here, bus and function pins are not
`include "param_source_map.vh"
`timescale 1ns/100ps
`default_nettype none
module param_source_control #(
  parameter NPROF = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire external_powerdown_pin_i,
  input wire global_clear_i,
  input wire commit_strobe_i,
  input wire [2:0] profile_select_pins_i,
  input wire [3:0] function_select_pins_i,
  input wire [31:0] parallel_data_bus_i,
  input wire ramp_direction_pin_i,
  input wire ramp_pause_pin_i,
  input wire [11:0] amplitude_keying_amp_i,
  output reg data_clock_o,
  output reg ramp_limit_flag_o,
  output reg [7:0] powerdown_o,
  output reg [31:0] freq_o,
  output reg [15:0] phase_o,
  output reg [11:0] amp_o
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] pd_s, clr_s, com_s, dir_s, pau_s;
  reg [2:0] ps_s1, ps_s2, ps_last;
  always @(posedge clk_i)
  begin
    pd_s <= {pd_s[0], external_powerdown_pin_i};
    clr_s <= {clr_s[0], global_clear_i};
    com_s <= {com_s[0], commit_strobe_i};
    dir_s <= {dir_s[0], ramp_direction_pin_i};
    pau_s <= {pau_s[0], ramp_pause_pin_i};
    ps_s1 <= profile_select_pins_i;
    ps_s2 <= ps_s1;
  end
  // bus and keying inputs are sampled only at data clock rising edges
  wire clr = rst_i | clr_s[1];
  ////////////////////////////////////////////////////////////////////
  // data clock divider
  reg [3:0] div_cnt, fn_act;
  wire dclk_rise = (div_cnt == 4'h0);
  always @(posedge clk_i)
  begin
    if (clr)
    begin
      div_cnt <= 4'h0;
      data_clock_o <= 1'b0;
    end
    else
    begin
      div_cnt <= div_cnt + 4'h1;
      data_clock_o <= (div_cnt < (`DCLK_DIV / 2));
    end
  end
  ////////////////////////////////////////////////////////////////////
  // buffered and active registers
  reg [31:0] b_ctrl0, b_mode, b_up, b_lo, b_rs, b_fs, b_rr, b_fr, b_mf;
  reg [31:0] a_ctrl0, a_mode, a_up, a_lo, a_rs, a_fs, a_rr, a_fr, a_mf;
  reg [2:0] b_psel, ps_act;
  reg [31:0] b_pf [0:NPROF-1];
  reg [15:0] b_pp [0:NPROF-1];
  reg [11:0] b_pa [0:NPROF-1];
  reg [31:0] a_pf [0:NPROF-1];
  reg [15:0] a_pp [0:NPROF-1];
  reg [11:0] a_pa [0:NPROF-1];
  reg [31:0] par_word, next_freq;
  reg [11:0] key_amp, next_amp;
  wire ps_change = dclk_rise && (ps_s2 != ps_last);
  wire commit = dclk_rise && (com_s[1] || ps_change);
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge[k*8 +: 8] = sel[k] ? dat[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction
  always @(posedge clk_i)
  begin
    if (clr)
    begin
      b_ctrl0 <= `CTRL0_RESET;
      b_mode <= `MODE_RESET;
      b_up <= 32'h00000000;
      b_lo <= 32'h00000000;
      b_rs <= 32'h00000000;
      b_fs <= 32'h00000000;
      b_rr <= 32'h00000000;
      b_fr <= 32'h00000000;
      b_mf <= 32'h00000000;
      b_psel <= 3'h0;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `REG_CTRL0: b_ctrl0 <= merge(b_ctrl0, wb_dat_i, wb_sel_i);
        `REG_MODE: b_mode <= merge(b_mode, wb_dat_i, wb_sel_i);
        `REG_PROF_SEL: b_psel <= wb_sel_i[0] ? wb_dat_i[2:0] : b_psel;
        `REG_RAMP_UPPER: b_up <= merge(b_up, wb_dat_i, wb_sel_i);
        `REG_RAMP_LOWER: b_lo <= merge(b_lo, wb_dat_i, wb_sel_i);
        `REG_RAMP_RSTEP: b_rs <= merge(b_rs, wb_dat_i, wb_sel_i);
        `REG_RAMP_FSTEP: b_fs <= merge(b_fs, wb_dat_i, wb_sel_i);
        `REG_RAMP_RRATE: b_rr <= merge(b_rr, wb_dat_i, wb_sel_i);
        `REG_RAMP_FRATE: b_fr <= merge(b_fr, wb_dat_i, wb_sel_i);
        `REG_MOD_FREQ: b_mf <= merge(b_mf, wb_dat_i, wb_sel_i);
        default: b_psel <= b_psel;
      endcase
    end
  end
  genvar g;
  generate
    for (g = 0; g < NPROF; g = g + 1)
    begin : prof
      always @(posedge clk_i)
      begin
        if (clr)
        begin
          b_pf[g] <= 32'h00000000;
          b_pp[g] <= 16'h0000;
          b_pa[g] <= 12'h000;
          a_pf[g] <= 32'h00000000;
          a_pp[g] <= 16'h0000;
          a_pa[g] <= 12'h000;
        end
        else
        begin
          if (wr && b_psel == g && wb_adr_i == `REG_PROF_FREQ)
            b_pf[g] <= merge(b_pf[g], wb_dat_i, wb_sel_i);
          if (wr && b_psel == g && wb_adr_i == `REG_PROF_PHASE)
            b_pp[g] <= wb_dat_i[15:0];
          if (wr && b_psel == g && wb_adr_i == `REG_PROF_AMP)
            b_pa[g] <= wb_dat_i[11:0];
          if (commit)
          begin
            a_pf[g] <= b_pf[g];
            a_pp[g] <= b_pp[g];
            a_pa[g] <= b_pa[g];
          end
        end
      end
    end
  endgenerate
  always @(posedge clk_i)
  begin
    if (clr)
    begin
      a_ctrl0 <= `CTRL0_RESET;
      a_mode <= `MODE_RESET;
      a_up <= 32'h00000000;
      a_lo <= 32'h00000000;
      a_rs <= 32'h00000000;
      a_fs <= 32'h00000000;
      a_rr <= 32'h00000000;
      a_fr <= 32'h00000000;
      a_mf <= 32'h00000000;
      ps_act <= 3'h0;
      ps_last <= 3'h0;
      par_word <= 32'h00000000;
      fn_act <= 4'h0;
      key_amp <= 12'h000;
    end
    else
    begin
      if (commit)
      begin
        a_ctrl0 <= b_ctrl0;
        a_mode <= b_mode;
        a_up <= b_up;
        a_lo <= b_lo;
        a_rs <= b_rs;
        a_fs <= b_fs;
        a_rr <= b_rr;
        a_fr <= b_fr;
        a_mf <= b_mf;
      end
      if (dclk_rise)
      begin
        ps_last <= ps_s2;
        ps_act <= ps_s2;
        par_word <= parallel_data_bus_i;
        fn_act <= function_select_pins_i;
        key_amp <= amplitude_keying_amp_i;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // ramp and source priority
  wire [31:0] ramp_val;
  wire ramp_lim;
  wire key_en = a_ctrl0[`CTRL0_KEY_EN];
  wire en_par = a_mode[`MODE_PARALLEL];
  wire en_prof = a_mode[`MODE_PROFILE];
  wire en_ramp = a_mode[`MODE_RAMP];
  wire en_mod = a_mode[`MODE_MODULUS];
  wire [1:0] tgt = a_mode[`MODE_TGT_LO +: 2];
  ramp_generator #(.WIDTH(32)) u_ramp (
    .clk_i(clk_i),
    .rst_i(clr),
    .enable_i(en_ramp),
    .dir_up_i(dir_s[1]),
    .pause_i(pau_s[1]),
    .upper_i(a_up),
    .lower_i(a_lo),
    .rise_step_i(a_rs),
    .fall_step_i(a_fs),
    .rise_rate_i(a_rr[15:0]),
    .fall_rate_i(a_fr[15:0]),
    .value_o(ramp_val),
    .at_limit_o(ramp_lim)
  );
  reg [15:0] next_phase;
  always @*
  begin
    next_freq = a_pf[ps_act]; // unmodulated from profile
    next_phase = a_pp[ps_act];
    next_amp = key_en ? a_pa[ps_act] : 12'hFFF;
    if (en_par && !en_prof) // lowest first, later wins
    begin
      case (fn_act)
        4'h0: next_freq = par_word;
        4'h1: next_phase = par_word[31:16];
        4'h2: next_amp = par_word[31:20];
        4'h3: // polar drives phase and amplitude together
        begin
          next_phase = par_word[31:16];
          next_amp = par_word[15:4];
        end
        default: next_freq = next_freq;
      endcase
    end
    if (en_ramp && !en_mod)
    begin
      case (tgt)
        `TGT_FREQ: next_freq = ramp_val;
        `TGT_PHASE: next_phase = ramp_val[31:16];
        `TGT_AMP: next_amp = key_en ? ramp_val[31:20] : next_amp;
        default: next_freq = next_freq;
      endcase
    end
    if (en_mod)
      next_freq = a_mf; // modulus owns frequency outright
    if (key_en && a_ctrl0[9])
      next_amp = key_amp;
  end
  always @(posedge clk_i)
  begin
    if (clr)
    begin
      freq_o <= 32'h00000000;
      phase_o <= 16'h0000;
      amp_o <= 12'h000;
      ramp_limit_flag_o <= 1'b0;
      powerdown_o <= 8'h00;
    end
    else
    begin
      freq_o <= next_freq;
      phase_o <= next_phase;
      amp_o <= next_amp;
      ramp_limit_flag_o <= ramp_lim & en_ramp;
      powerdown_o <= pd_s[1] ? a_ctrl0[`CTRL0_PD_LO +: 8] : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // wishbone read and ack, one wait state free answer
  always @(posedge clk_i)
  begin
    if (clr)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        `REG_CTRL0: wb_dat_o <= b_ctrl0;
        `REG_MODE: wb_dat_o <= b_mode;
        `REG_PROF_SEL: wb_dat_o <= {29'h0, b_psel};
        `REG_PROF_FREQ: wb_dat_o <= b_pf[b_psel];
        `REG_PROF_PHASE: wb_dat_o <= {16'h0000, b_pp[b_psel]};
        `REG_PROF_AMP: wb_dat_o <= {20'h00000, b_pa[b_psel]};
        `REG_RAMP_UPPER: wb_dat_o <= b_up;
        `REG_RAMP_LOWER: wb_dat_o <= b_lo;
        `REG_RAMP_RSTEP: wb_dat_o <= b_rs;
        `REG_RAMP_FSTEP: wb_dat_o <= b_fs;
        `REG_RAMP_RRATE: wb_dat_o <= b_rr;
        `REG_RAMP_FRATE: wb_dat_o <= b_fr;
        `REG_MOD_FREQ: wb_dat_o <= b_mf;
        `REG_STATUS: wb_dat_o <= {24'h000000, ps_act, 1'b0, pd_s[1],
                                  dir_s[1], pau_s[1], ramp_lim};
        `REG_OUT_FREQ: wb_dat_o <= freq_o;
        `REG_OUT_PHASE: wb_dat_o <= {16'h0000, phase_o};
        `REG_OUT_AMP: wb_dat_o <= {20'h00000, amp_o};
        `REG_KEY_AMP: wb_dat_o <= {20'h00000, key_amp};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule // param_source_control
`default_nettype wire

// >>> test/param_source_control_asserts.sv
// concurrent checks on the parameter source control ports
// assumes one clock, sync reset; global clear lags through a synchroniser
`timescale 1ns/100ps
`default_nettype none
module param_source_control_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic global_clear_i,
  input wire logic external_powerdown_pin_i,
  input wire logic data_clock_o,
  input wire logic [7:0] powerdown_o,
  input wire logic [11:0] amp_o
);
  // clear acts late, so checks stay off a few cycles beyond it
  logic [5:0] clr_hist = 6'h00;
  always @(posedge clk_i)
  begin
    clr_hist <= {clr_hist[4:0], global_clear_i};
  end
  default clocking dflt @(posedge clk_i);
  endclocking
  default disable iff (rst_i || global_clear_i || |clr_hist);
  ////////////////////////////////////////////////////////////////////
  sequence high_run;
    data_clock_o [*8] ##1 !data_clock_o;
  endsequence
  sequence low_run;
    !data_clock_o [*8] ##1 data_clock_o;
  endsequence
  sequence pin_low_run;
    !external_powerdown_pin_i [*4];
  endsequence
  a_dclk_high_run: assert property ($rose(data_clock_o) |-> high_run)
    else $error("data clock high phase wrong");
  a_dclk_low_run: assert property ($fell(data_clock_o) |-> low_run)
    else $error("data clock low phase wrong");
  a_pd_released: assert property (pin_low_run |-> powerdown_o == 8'h00)
    else $error("power-down output without pin");
  a_amp_full_scale: assert property ($fell(rst_i) |-> ##[0:2] amp_o == 12'hFFF)
    else $error("amplitude not full scale after reset");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_only_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i &&
    !wb_ack_o && wb_adr_i > 8'h44 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // param_source_control_asserts
bind param_source_control param_source_control_asserts chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .global_clear_i(global_clear_i),
  .external_powerdown_pin_i(external_powerdown_pin_i),
  .data_clock_o(data_clock_o), .powerdown_o(powerdown_o), .amp_o(amp_o));
`default_nettype wire

// >>> test/pin_controller_model.sv
// external controller model for the pin side
// assumes the data clock from the block; bench posts the wanted levels
`timescale 1ns/100ps
`default_nettype none
module pin_controller_model (
  input wire logic clk_i,
  input wire logic data_clock_i,
  input wire logic [2:0] req_profile_i,
  input wire logic req_commit_i,
  input wire logic [3:0] req_func_i,
  input wire logic [31:0] req_data_i,
  output var logic [2:0] profile_o,
  output var logic commit_o,
  output var logic [3:0] func_o,
  output var logic [31:0] data_o
);
  logic last_dclk = 1'b0;
  initial
  begin
    profile_o = 3'h0;
    commit_o = 1'b0;
    func_o = 4'h0;
    data_o = 32'h0;
  end
  always @(posedge clk_i)
  begin
    last_dclk <= data_clock_i;
    // change on the fall: half a period of setup before the next rise
    if (last_dclk && !data_clock_i)
    begin
      profile_o <= req_profile_i;
      commit_o <= req_commit_i;
      func_o <= req_func_i;
      data_o <= req_data_i;
    end
  end
endmodule // pin_controller_model
`default_nettype wire

// >>> test/param_source_control_test.sv
// self-checking bench for the parameter source control block
// profile, commit, function and data pins come through the controller model; registers over wishbone
`include "param_source_map.vh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module param_source_control_test;
  logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic pd = 1'b0, gclr = 1'b0, dir = 1'b0, pause = 1'b0, commit = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, r, bus = 32'h0;
  logic [31:0] msk [3] = '{32'hFFFFFFFF, 32'hFFFF0000, 32'hFFF00000};
  logic [2:0] prof = 3'h0;
  logic [3:0] func = 4'h0;
  wire [31:0] rdat, pdata, fq;
  wire ack, dclk, flag, pcommit;
  wire [2:0] pprof;
  wire [3:0] pfunc;
  wire [7:0] pdo;
  wire [15:0] ph;
  wire [11:0] am;
  int err_count = 0, check_count = 0, i;
  param_source_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_powerdown_pin_i(pd), .global_clear_i(gclr),
    .commit_strobe_i(pcommit), .profile_select_pins_i(pprof),
    .function_select_pins_i(pfunc), .parallel_data_bus_i(pdata),
    .ramp_direction_pin_i(dir), .ramp_pause_pin_i(pause),
    .amplitude_keying_amp_i(12'h5A3), .data_clock_o(dclk),
    .ramp_limit_flag_o(flag), .powerdown_o(pdo), .freq_o(fq),
    .phase_o(ph), .amp_o(am));
  pin_controller_model pcm (.clk_i(clk_i), .data_clock_i(dclk),
    .req_profile_i(prof), .req_commit_i(commit), .req_func_i(func),
    .req_data_i(bus), .profile_o(pprof), .commit_o(pcommit),
    .func_o(pfunc), .data_o(pdata));
  ////////////////////////////////////////////////////////////////////
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task dc(input int n);
    repeat (n) @(posedge dclk);
    @(posedge clk_i);
  endtask
  task cm;
    commit <= 1'b1;
    dc(3);
    commit <= 1'b0;
    dc(3);
  endtask
  function automatic logic [31:0] rv(input int t);
    return t == 0 ? fq : t == 1 ? {ph, 16'h0} : {am, 20'h0};
  endfunction
  task test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // whole run is under 2000 cycles
  initial
  begin
    tk(20000);
    err_count++;
    test_done();
  end
  initial
  begin
    tk(3);
    rst_i <= 1'b0;
    tk(1);
    xfer(0, `REG_CTRL0, 0);
    `CHK(r, `CTRL0_RESET)
    xfer(0, `REG_MODE, 0);
    `CHK(r, `MODE_RESET)
    xfer(0, 8'h80, 0);
    `CHK(r, 32'h0)
    for (i = 0; i < 8; i++)
    begin
      xfer(1, `REG_PROF_SEL, i);
      xfer(1, `REG_PROF_FREQ, 32'h10000000 | i);
      xfer(1, `REG_PROF_PHASE, 32'h2000 | i);
      xfer(1, `REG_PROF_AMP, 32'h700 | i);
    end
    for (i = 7; i >= 0; i--)
    begin
      prof <= i[2:0];
      dc(3);
      `CHK(fq, 32'h10000000 | i)
      `CHK(ph, 16'h2000 | i[15:0])
      `CHK(am, 12'hFFF)
    end
    xfer(1, `REG_CTRL0, 32'h100);
    cm();
    `CHK(am, 12'h700)
    xfer(1, `REG_CTRL0, 32'h300);
    cm();
    `CHK(am, 12'h5A3)
    xfer(1, `REG_CTRL0, 32'h15A);
    xfer(1, `REG_PROF_SEL, 0);
    xfer(1, `REG_PROF_FREQ, 32'h0BAD0000);
    dc(3);
    `CHK(fq, 32'h10000000)
    cm();
    `CHK(fq, 32'h0BAD0000)
    pd <= 1'b1;
    tk(6);
    `CHK(pdo, 8'h5A)
    pd <= 1'b0;
    tk(6);
    `CHK(pdo, 8'h00)
    bus <= 32'hCAFEBEEF;
    xfer(1, `REG_MODE, 32'h400000);
    cm();
    for (i = 0; i < 4; i++)
    begin
      func <= i[3:0];
      dc(3);
      `CHK(fq, i == 0 ? bus : 32'h0BAD0000)
      `CHK(ph, i[0] ? bus[31:16] : 16'h2000)
      `CHK(am, i == 2 ? bus[31:20] : i == 3 ? bus[15:4] : 12'h700)
    end
    xfer(1, `REG_MODE, 32'hC00000);
    func <= 4'h0;
    cm();
    `CHK(fq, 32'h0BAD0000)
    xfer(1, `REG_RAMP_LOWER, 32'h10000000);
    xfer(1, `REG_RAMP_UPPER, 32'h30000000);
    xfer(1, `REG_RAMP_RSTEP, 32'h08000000);
    xfer(1, `REG_RAMP_FSTEP, 32'h10000000);
    xfer(1, `REG_RAMP_RRATE, 32'h1);
    for (i = 0; i < 3; i++)
    begin
      xfer(1, `REG_MODE, 32'h80000 | (i << 20));
      cm();
      dir <= 1'b1;
      tk(24);
      `CHK(rv(i), 32'h30000000 & msk[i])
      `CHK(flag, 1'b1)
      pause <= 1'b1;
      dir <= 1'b0;
      tk(24);
      `CHK(rv(i), 32'h30000000 & msk[i])
      pause <= 1'b0;
      tk(24);
      `CHK(rv(i), 32'h10000000 & msk[i])
    end
    xfer(1, `REG_MOD_FREQ, 32'h12345678);
    xfer(1, `REG_MODE, 32'hA0000);
    cm();
    `CHK(fq, 32'h12345678)
    `CHK(ph, 16'h2000)
    `CHK(am, 12'h700)
    gclr <= 1'b1;
    tk(4);
    gclr <= 1'b0;
    tk(8);
    xfer(0, `REG_CTRL0, 0);
    `CHK(r, `CTRL0_RESET)
    `CHK(fq, 32'h0)
    `CHK(am, 12'hFFF)
    `CHK(flag, 1'b0)
    test_done();
  end
endmodule // param_source_control_test
`default_nettype wire
